// >>> rtl/asrm_host.sv
// host controller driving an asynchronous 256K x 9 static memory module
`timescale 1ns/10ps
`default_nettype none
module asrm_host
  import asrm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,               // request from user logic
  input wire logic req_write,               // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr,   // word address of request
  input wire logic [DATA_W-1:0] req_wdata,  // word to write
  output logic req_ready,                   // request taken when valid and ready
  output logic rsp_valid,                   // one-cycle pulse with read word
  output logic [DATA_W-1:0] rsp_rdata,      // read word
  output logic [ADDR_W-1:0] word_address,   // memory address lines
  output logic [DATA_W-1:0] write_data_in,  // memory data inputs
  output logic select_n,                    // memory select, active low
  output logic write_strobe_n,              // memory write strobe, active low
  input wire logic [DATA_W-1:0] read_data_out // memory data outputs, asynchronous
);
  // ----------------------------------------------------------------
  // timing plan
  // ----------------------------------------------------------------
  // every least time of the memory is far below one clock period
  // so each phase lasts whole cycles, counted down in cnt_r
  // counts come rounded up from the package; a clock of 14 ns or more only
  // needs new figures there, a faster one also new cycle counts in the assertions here
  // write: take, setup, pulse, recovery, then ready again
  // read: take, access wait, deselect wait, then ready again
  // the memory outputs change with no clock at all, so the read
  // word passes two flip-flops and is taken only once settled
  // address and write word never move while a write is open
  // ----------------------------------------------------------------
  // read data synchroniser
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_meta_r; // first stage, read only by second
  logic [DATA_W-1:0] rd_sync_r; // second stage
  // both stages sample every cycle; the word is used only after the
  // access wait has let it settle, so no bit is caught mid-change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // both stages clear so no stale word is seen after reset
      rd_meta_r <= '0;
      rd_sync_r <= '0;
    end else begin
      rd_meta_r <= read_data_out;
      rd_sync_r <= rd_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  asrm_state_e state_r; // current phase
  logic [CNT_W-1:0] cnt_r; // cycles left in phase
  // four bits hold every phase count of the package with room to spare
  logic take; // request accepted this cycle
  // ready is a flop, so a take never waits on this cycle's decode
  assign take = req_valid && req_ready;

  // state and phase counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // start deselected with no phase running
      state_r <= ASRM_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      // one phase per state; cnt_r holds the cycles left in it
      case (state_r)
        ASRM_IDLE: begin
          // memory deselected and in standby until a request is taken
          if (take) begin
            // a write places address and data first, a read selects at once
            state_r <= req_write ? ASRM_SETUP : ASRM_READ;
            cnt_r <= req_write ? CNT_ONE : ACCESS_CNT;
          end
        end
        ASRM_SETUP: begin
          // address and data settle one cycle before select and strobe fall together
          state_r <= ASRM_WPULSE;
          cnt_r <= PULSE_CNT;
        end
        ASRM_WPULSE: begin
          // select and strobe stay low for the pulse count
          // the last count raises both so recovery starts together
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRM_WRECOV;
            cnt_r <= RECOV_CNT;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ASRM_READ: begin
          // select stays low while the word settles and is synchronised
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRM_DESEL;
            cnt_r <= IDLE_CNT;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ASRM_WRECOV, ASRM_DESEL: begin
          // strobes high; the memory floats its outputs and drops to standby
          if (cnt_r == CNT_ONE) begin
            state_r <= ASRM_IDLE;
            cnt_r <= CNT_ZERO;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          // unused code: back to idle with the memory deselected
          state_r <= ASRM_IDLE;
          cnt_r <= CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory pins
  // ----------------------------------------------------------------
  // address and data latch only while deselected
  // a take only happens in idle, where select has been high a cycle
  // a read latches the unused write word too; the memory ignores it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_address <= '0;
      write_data_in <= '0;
    end else if (take) begin
      word_address <= req_addr;
      write_data_in <= req_wdata;
    end
  end

  // select low in write pulse and read; strobe low only in write pulse
  // both fall on one edge in a write so the outputs never drive
  // both rise on the last count, before the address may move again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      select_n <= !((state_r == ASRM_SETUP) || (state_r == ASRM_WPULSE && cnt_r != CNT_ONE) ||
                    (take && !req_write) || (state_r == ASRM_READ && cnt_r != CNT_ONE));
      write_strobe_n <= !((state_r == ASRM_SETUP) || (state_r == ASRM_WPULSE && cnt_r != CNT_ONE));
    end
  end

  // ----------------------------------------------------------------
  // user side
  // ----------------------------------------------------------------
  // ready only when idle and the next cycle stays idle
  // ready rises on the last recovery or deselect count so no cycle is lost
  // and drops on the take edge so a second request waits its turn
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_r == ASRM_IDLE && !take) ||
                   ((state_r == ASRM_WRECOV || state_r == ASRM_DESEL) && cnt_r == CNT_ONE);
    end
  end

  // sample read word after access time and synchroniser
  // rsp_rdata keeps the last word until the next read ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_r == ASRM_READ && cnt_r == CNT_ONE);
      if (state_r == ASRM_READ && cnt_r == CNT_ONE) begin
        rsp_rdata <= rd_sync_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // all checks run on the controller clock and watch the pins and the internal take
  // an address change is legal while select or strobe is high on both sides
  addr_stable_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(word_address) |-> ($past(select_n) && select_n) || ($past(write_strobe_n) && write_strobe_n))
    else $error("address changed during a write");
  strobe_needs_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe_n |-> !select_n) else $error("strobe low without select");
  // strobe only falls on the edge where select falls, never after it
  strobe_with_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_strobe_n) |-> $fell(select_n)) else $error("select fell before strobe");
  pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_strobe_n) |-> !write_strobe_n [*1] ##1 write_strobe_n) else $error("strobe pulse width wrong");
  recovery_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_strobe_n) |-> !req_ready ##1 req_ready) else $error("recovery too short");
  // answer shows on the edge where the three-cycle access count ends, three edges after select falls
  read_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(select_n) && write_strobe_n |-> ##3 rsp_valid) else $error("read answer late");
  rsp_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid |-> ##1 !rsp_valid) else $error("read answer held too long");
  deselect_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(select_n) |-> select_n ##1 select_n) else $error("reselected too soon");
  one_op_a: assert property (@(posedge clk) disable iff (!rst_n)
    take |-> ##1 !req_ready) else $error("ready held after take");
  data_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe_n |-> $stable(write_data_in) && $stable(word_address)) else $error("write word moved in pulse");
  ready_desel_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_ready |-> select_n && write_strobe_n) else $error("ready while memory selected");
  // main scenarios
  c_write: cover property (@(posedge clk) disable iff (!rst_n) take && req_write);
  c_read_wait: cover property (@(posedge clk) disable iff (!rst_n) $fell(select_n) && write_strobe_n ##3 rsp_valid);
  c_read: cover property (@(posedge clk) disable iff (!rst_n) rsp_valid);
  c_back: cover property (@(posedge clk) disable iff (!rst_n) rsp_valid ##[1:4] !write_strobe_n);
endmodule
`default_nettype wire

// >>> rtl/asrm_pkg.sv
// constants shared by the static memory host controller
package asrm_pkg;
  localparam int unsigned ADDR_W = 18;            // word address lines
  localparam int unsigned DATA_W = 9;             // data word width
  localparam int unsigned CLK_PERIOD_NS = 50;     // 20 MHz system clock
  // fastest grade timing figures in ns
  localparam int unsigned WRITE_CYCLE_NS = 10;    // least write cycle
  localparam int unsigned WRITE_PULSE_NS = 8;     // least strobe pulse / select / address to end of write
  localparam int unsigned DATA_OVERLAP_NS = 8;    // least data valid before end of write
  localparam int unsigned WRITE_FLOAT_NS = 6;     // longest strobe-to-float of the memory
  localparam int unsigned WRITE_RECOVERY_NS = 0;  // least recovery after write
  localparam int unsigned ACCESS_NS = 10;         // longest access time, equal to read cycle
  localparam int unsigned DESELECT_FLOAT_NS = 10; // longest deselect to float
  localparam int unsigned POWER_DOWN_NS = 10;     // longest deselect to standby
  // least times round up, none below one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned PULSE_CYC = ns_to_cyc((WRITE_PULSE_NS > WRITE_FLOAT_NS + DATA_OVERLAP_NS) ?
                                                WRITE_PULSE_NS : WRITE_FLOAT_NS + DATA_OVERLAP_NS);
  localparam int unsigned RECOV_CYC = ns_to_cyc(WRITE_RECOVERY_NS + WRITE_CYCLE_NS - WRITE_PULSE_NS);
  // sampling waits for access time plus two synchroniser stages
  localparam int unsigned ACCESS_CYC = ns_to_cyc(ACCESS_NS) + 2;
  localparam int unsigned IDLE_CYC = ns_to_cyc(DESELECT_FLOAT_NS > POWER_DOWN_NS ? DESELECT_FLOAT_NS : POWER_DOWN_NS);
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] RECOV_CNT = CNT_W'(RECOV_CYC);
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] IDLE_CNT = CNT_W'(IDLE_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // controller states, one-hot
  typedef enum logic [5:0] {
    ASRM_IDLE  = 6'h01, // deselected, standby
    ASRM_SETUP = 6'h02, // address and data placed, strobes high
    ASRM_WPULSE = 6'h04, // select and strobe low
    ASRM_WRECOV = 6'h08, // strobe high, select high, address held
    ASRM_READ  = 6'h10, // selected, waiting access time
    ASRM_DESEL = 6'h20  // deselected, waiting float and power down
  } asrm_state_e;
endpackage

// >>> verification/asrm_mem_model.sv
// behavioural model of the asynchronous 256K x 9 static memory module
`timescale 1ns/10ps
`default_nettype none
module asrm_mem_model
  import asrm_pkg::*;
(
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic select_n,
  input wire logic write_strobe_n,
  output logic [DATA_W-1:0] read_data_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // full word array
  // ----------------------------------------
  // level driven store and read, no clock
  // ----------------------------------------
  initial begin
    read_data_out = 9'h155;
    foreach (mem[i]) mem[i] = '0; // unwritten words read as zero
  end
  always @(word_address or write_data_in or select_n or write_strobe_n) begin
    if (select_n) begin
      read_data_out <= #10 ~read_data_out; // floating, standby
    end else if (!write_strobe_n) begin
      mem[word_address] = write_data_in; // store while both low
      read_data_out <= #6 ~read_data_out; // floating in write
    end else begin
      read_data_out <= #3 ~read_data_out; // old word held, then changing
      read_data_out <= #10 mem[word_address];
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module tb
  import asrm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, rsp_valid, select_n, write_strobe_n;
  logic [DATA_W-1:0] rsp_rdata, write_data_in, read_data_out, cur_data;
  logic [ADDR_W-1:0] word_address, cur_addr;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] lfsr_r = 16'hFB9E; // random source
  logic [DATA_W-1:0] exp_mem [0:(1<<ADDR_W)-1]; // expected contents
  logic [ADDR_W-1:0] addr_tab [4] = '{18'h00000, 18'h3FFFF, 18'h2AAAA, 18'h15555};

  asrm_host dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address(word_address), .write_data_in(write_data_in), .select_n(select_n),
    .write_strobe_n(write_strobe_n), .read_data_out(read_data_out));
  asrm_mem_model mem_u (.word_address(word_address), .write_data_in(write_data_in), .select_n(select_n),
    .write_strobe_n(write_strobe_n), .read_data_out(read_data_out));

  always #25 clk = ~clk;
  // ----------------------------------------
  // watchdog and write-window monitor
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (rst_n && select_n === 1'b0 && write_strobe_n === 1'b0) begin
      `CHK("address in write", cur_addr, word_address)
      `CHK("data in write", cur_data, write_data_in)
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [DATA_W-1:0] expect_word(input logic [ADDR_W-1:0] a);
    return exp_mem[a];
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one request, held until taken; reads are compared
  task automatic do_req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    `CHK("request taken", 1'b1, req_ready)
    cur_addr = a;
    cur_data = d;
    #2;
    req_valid = 1'b0;
    req_addr = {lfsr_r, 2'b10};
    req_wdata = ~d;
    n = 0;
    if (wr) begin
      exp_mem[a] = d;
    end else begin
      do begin
        @(posedge clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 12);
      `CHK("read latency", int'(ACCESS_CYC) + 1, n)
      `CHK("read word", expect_word(a), rsp_rdata)
    end
    @(posedge clk);
    #2;
  endtask

  initial begin
    foreach (exp_mem[i]) exp_mem[i] = '0; // unwritten words read as zero
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    foreach (addr_tab[i]) do_req(1'b1, addr_tab[i], i[0] ? 9'h1FF : 9'h000);
    foreach (addr_tab[i]) do_req(1'b0, addr_tab[i], 9'h000);
    repeat (80) begin
      lfsr_r = lfsr_next(lfsr_r);
      do_req(lfsr_r[0], addr_tab[lfsr_r[2:1]], lfsr_r[11:3]);
    end
    rst_n = 1'b0;
    @(posedge clk);
    #2;
    `CHK("select in reset", 1'b1, select_n)
    `CHK("strobe in reset", 1'b1, write_strobe_n)
    `CHK("ready in reset", 1'b0, req_ready)
    `CHK("answer in reset", 1'b0, rsp_valid)
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    `CHK("ready after reset", 1'b1, req_ready)
    do_req(1'b0, addr_tab[1], 9'h000);
    finish_test();
  end
endmodule
`default_nettype wire
